/* core/dsom_ctrl.sv */
// stop-option codes, halt handling, mode select/display and mode status bits
`timescale 1ns/1ns
`include "dsom_map.svh"

module dsom_ctrl #(
    parameter int RATE_W = 32
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // object dictionary access
    input wire dsom_pkg::dsom_od_req_t od_req,
    output dsom_pkg::dsom_od_rsp_t od_rsp,
    // controlword and drive events
    input wire logic [15:0] ctrl_word,
    input wire dsom_pkg::dsom_evt_t evt,
    // motion core feedback and rate objects
    input wire dsom_pkg::dsom_fb_t fb,
    input wire logic [RATE_W-1:0] profile_decel,
    input wire logic [RATE_W-1:0] homing_accel,
    input wire logic [RATE_W-1:0] quick_decel,
    // stop command to the motion core
    output dsom_pkg::dsom_act_t stop_act,
    output logic [RATE_W-1:0] decel_rate,
    output logic torque_zero,
    output logic to_sod,
    // status and mode display
    output logic [15:0] status_bits,
    output logic [7:0] mode_display,
    // nonvolatile store
    output dsom_pkg::dsom_nv_t nv_store
);
    import dsom_pkg::*;

    // ****************************************************************
    // decode helpers
    // ****************************************************************

    // stop option value to action; unknown codes fall back to servo off
    function automatic dsom_act_t opt_act(input logic [15:0] v);
        case (v)
            16'h0000: opt_act = DSOM_ACT_SRVOFF;
            16'h0001: opt_act = DSOM_ACT_DEC_NORM;
            16'h0002: opt_act = DSOM_ACT_DEC_QUICK;
            16'h0003: opt_act = DSOM_ACT_DEC_TLIM;
            default: opt_act = DSOM_ACT_SRVOFF;
        endcase
    endfunction

    // halt has no servo-off choice, so 0 and 4 take the normal rate
    function automatic dsom_act_t halt_act(input logic [15:0] v);
        case (v)
            16'h0002: halt_act = DSOM_ACT_DEC_QUICK;
            16'h0003: halt_act = DSOM_ACT_DEC_TLIM;
            default: halt_act = DSOM_ACT_DEC_NORM;
        endcase
    endfunction

    function automatic logic is_torque(input logic [7:0] m);
        is_torque = (m == `DSOM_MODE_PT) || (m == `DSOM_MODE_CST);
    endfunction

    // only the listed codes switch the mode
    function automatic logic mode_defined(input logic [7:0] m);
        case (m)
            `DSOM_MODE_PP, `DSOM_MODE_PV, `DSOM_MODE_PT, `DSOM_MODE_HM,
            `DSOM_MODE_IP, `DSOM_MODE_CSP, `DSOM_MODE_CSV,
            `DSOM_MODE_CST: mode_defined = 1'b1;
            default: mode_defined = 1'b0;
        endcase
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    localparam dsom_st_t ST_RST = '{
        fsm: DSOM_ST_IDLE,
        act: DSOM_ACT_NONE,
        to_sod: 1'b0,
        torque_zero: 1'b0,
        opt_qstop: `DSOM_RST_QSTOP,
        opt_shut: `DSOM_RST_SHUT,
        opt_disop: `DSOM_RST_DISOP,
        opt_halt: `DSOM_RST_HALT,
        opt_fault: `DSOM_RST_FAULT,
        mode_sel: `DSOM_RST_MODE,
        mode_act: `DSOM_MODE_NONE,
        status: 16'h0000,
        rsp: '0,
        nv: '0
    };

    dsom_st_t st_q;
    dsom_st_t st_d;
    logic [RATE_W-1:0] rate_q;
    logic [RATE_W-1:0] rate_d;

    // ****************************************************************
    // next-state logic
    // ****************************************************************

    // one pass: object access, stop sequencing, status; the rate select is the next block
    always_comb begin
        logic halt;
        logic trq;
        logic ok;
        halt = ctrl_word[`DSOM_CW_HALT];
        trq = is_torque(st_q.mode_act);
        ok = 1'b1;
        st_d = st_q;
        st_d.rsp.ack = 1'b0;
        st_d.rsp.err = 1'b0;
        st_d.nv.wr = 1'b0;
        st_d.to_sod = 1'b0;

        // object writes; option objects are never process data
        if (od_req.wr) begin
            st_d.rsp.ack = 1'b1;
            case (od_req.index)
                `DSOM_IDX_QSTOP: begin
                    if (!od_req.pdo && od_req.wdata <= `DSOM_MAX_QSTOP) begin
                        st_d.opt_qstop = od_req.wdata;
                    end else begin
                        ok = 1'b0;
                    end
                end
                `DSOM_IDX_SHUT: begin
                    if (!od_req.pdo && od_req.wdata <= `DSOM_MAX_SHUT) begin
                        st_d.opt_shut = od_req.wdata;
                    end else begin
                        ok = 1'b0;
                    end
                end
                `DSOM_IDX_DISOP: begin
                    if (!od_req.pdo && od_req.wdata <= `DSOM_MAX_DISOP) begin
                        st_d.opt_disop = od_req.wdata;
                    end else begin
                        ok = 1'b0;
                    end
                end
                `DSOM_IDX_HALT: begin
                    if (!od_req.pdo && od_req.wdata <= `DSOM_MAX_HALT) begin
                        st_d.opt_halt = od_req.wdata;
                    end else begin
                        ok = 1'b0;
                    end
                end
                `DSOM_IDX_FAULT: begin
                    if (!od_req.pdo && od_req.wdata <= `DSOM_MAX_FAULT) begin
                        st_d.opt_fault = od_req.wdata;
                    end else begin
                        ok = 1'b0;
                    end
                end
                `DSOM_IDX_MODE: begin
                    // mode select is a signed byte; upper byte must be clear
                    if (od_req.wdata[15:8] == 8'h00 &&
                        od_req.wdata[7:0] <= `DSOM_MAX_MODE) begin
                        st_d.mode_sel = od_req.wdata[7:0];
                        if (mode_defined(od_req.wdata[7:0])) begin
                            st_d.mode_act = od_req.wdata[7:0];
                        end
                    end else begin
                        ok = 1'b0;
                    end
                end
                default: ok = 1'b0; // display is read-only
            endcase
            st_d.rsp.err = !ok;
            // accepted values go to the nonvolatile store
            st_d.nv.wr = ok;
            st_d.nv.index = od_req.index;
            st_d.nv.data = od_req.wdata;
        end else if (od_req.rd) begin
            st_d.rsp.ack = 1'b1;
            case (od_req.index)
                `DSOM_IDX_QSTOP: st_d.rsp.rdata = st_q.opt_qstop;
                `DSOM_IDX_SHUT: st_d.rsp.rdata = st_q.opt_shut;
                `DSOM_IDX_DISOP: st_d.rsp.rdata = st_q.opt_disop;
                `DSOM_IDX_HALT: st_d.rsp.rdata = st_q.opt_halt;
                `DSOM_IDX_FAULT: st_d.rsp.rdata = st_q.opt_fault;
                `DSOM_IDX_MODE: st_d.rsp.rdata = {8'h00, st_q.mode_sel};
                `DSOM_IDX_MDISP: st_d.rsp.rdata = {8'h00, st_q.mode_act};
                default: begin
                    st_d.rsp.rdata = 16'h0000;
                    st_d.rsp.err = 1'b1;
                end
            endcase
        end

        // stop sequencer; an alarm outranks every other request
        st_d.torque_zero = 1'b0;
        if (evt.alarm) begin
            st_d.fsm = DSOM_ST_FAULT;
            st_d.act = DSOM_ACT_SRVOFF;
        end else begin
            case (st_q.fsm)
                DSOM_ST_IDLE: begin
                    if (evt.quick_stop) begin
                        st_d.fsm = DSOM_ST_STOP;
                        // torque modes cannot decelerate, so they cut the servo
                        st_d.act = trq ? DSOM_ACT_SRVOFF : opt_act(st_q.opt_qstop);
                    end else if (evt.shutdown) begin
                        st_d.fsm = DSOM_ST_STOP;
                        st_d.act = trq ? DSOM_ACT_SRVOFF : opt_act(st_q.opt_shut);
                    end else if (evt.disable_op) begin
                        st_d.fsm = DSOM_ST_STOP;
                        st_d.act = trq ? DSOM_ACT_SRVOFF : opt_act(st_q.opt_disop);
                    end else if (halt && !trq) begin
                        st_d.act = halt_act(st_q.opt_halt);
                    end else begin
                        st_d.act = DSOM_ACT_NONE;
                        st_d.torque_zero = halt && trq;
                    end
                end
                DSOM_ST_STOP: begin
                    // servo off finishes at once, ramps wait for standstill
                    if (st_q.act == DSOM_ACT_SRVOFF || fb.stopped) begin
                        st_d.to_sod = 1'b1;
                        st_d.fsm = DSOM_ST_IDLE;
                        st_d.act = DSOM_ACT_NONE;
                    end
                end
                DSOM_ST_FAULT: begin
                    st_d.act = DSOM_ACT_SRVOFF;
                    if (evt.fault_reset) begin
                        st_d.fsm = DSOM_ST_IDLE;
                        st_d.act = DSOM_ACT_NONE;
                    end
                end
                default: begin
                    st_d.fsm = DSOM_ST_IDLE;
                    st_d.act = DSOM_ACT_NONE;
                end
            endcase
        end

        // mode-specific status bits; other modes report zero here
        st_d.status = 16'h0000;
        if (st_q.mode_act == `DSOM_MODE_PV) begin
            st_d.status[`DSOM_SB_REACHED] = halt ? fb.stopped : fb.target_hit;
            st_d.status[`DSOM_SB_SPEED0] = fb.speed_zero;
        end else if (st_q.mode_act == `DSOM_MODE_PT) begin
            st_d.status[`DSOM_SB_REACHED] = halt ? fb.stopped : fb.target_hit;
        end
    end

    // rate follows the action chosen this cycle
    always_comb begin
        if (st_d.act == DSOM_ACT_DEC_QUICK) begin
            rate_d = quick_decel;
        end else if (st_d.mode_act == `DSOM_MODE_HM) begin
            rate_d = homing_accel;
        end else begin
            rate_d = profile_decel;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_q <= ST_RST;
            rate_q <= '0;
        end else begin
            st_q <= st_d;
            rate_q <= rate_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign od_rsp = st_q.rsp;
    assign stop_act = st_q.act;
    assign decel_rate = rate_q;
    assign torque_zero = st_q.torque_zero;
    assign to_sod = st_q.to_sod;
    assign status_bits = st_q.status;
    assign mode_display = st_q.mode_act;
    assign nv_store = st_q.nv;

endmodule

/* core/dsom_map.svh */
// object indices, reset values, limits and mode codes of the stop/mode block
`ifndef DSOM_MAP_SVH
`define DSOM_MAP_SVH

// ****************************************************************
// object dictionary indices
// ****************************************************************
`define DSOM_IDX_QSTOP 16'h605A
`define DSOM_IDX_SHUT 16'h605B
`define DSOM_IDX_DISOP 16'h605C
`define DSOM_IDX_HALT 16'h605D
`define DSOM_IDX_FAULT 16'h605E
`define DSOM_IDX_MODE 16'h6060
`define DSOM_IDX_MDISP 16'h6061

// ****************************************************************
// reset values and highest accepted values
// ****************************************************************
`define DSOM_RST_QSTOP 16'h0002
`define DSOM_RST_SHUT 16'h0000
`define DSOM_RST_DISOP 16'h0001
`define DSOM_RST_HALT 16'h0001
`define DSOM_RST_FAULT 16'h0000
`define DSOM_RST_MODE 8'h00
`define DSOM_MAX_QSTOP 16'h0004
`define DSOM_MAX_SHUT 16'h0001
`define DSOM_MAX_DISOP 16'h0001
`define DSOM_MAX_HALT 16'h0004
`define DSOM_MAX_FAULT 16'h0000
`define DSOM_MAX_MODE 8'h0A

// ****************************************************************
// operating mode codes
// ****************************************************************
`define DSOM_MODE_NONE 8'h00
`define DSOM_MODE_PP 8'h01
`define DSOM_MODE_PV 8'h03
`define DSOM_MODE_PT 8'h04
`define DSOM_MODE_HM 8'h06
`define DSOM_MODE_IP 8'h07
`define DSOM_MODE_CSP 8'h08
`define DSOM_MODE_CSV 8'h09
`define DSOM_MODE_CST 8'h0A

// ****************************************************************
// bit positions
// ****************************************************************
`define DSOM_CW_HALT 8
`define DSOM_SB_REACHED 10
`define DSOM_SB_SPEED0 12
`define DSOM_SB_B13 13

`endif

/* core/dsom_pkg.sv */
// types shared by the stop-option and mode-select block
package dsom_pkg;

    // stop action handed to the motion core
    typedef enum logic [2:0] {
        DSOM_ACT_NONE = 3'b000,
        DSOM_ACT_SRVOFF = 3'b001,
        DSOM_ACT_DEC_NORM = 3'b010,
        DSOM_ACT_DEC_QUICK = 3'b011,
        DSOM_ACT_DEC_TLIM = 3'b100
    } dsom_act_t;

    // stop sequencer states
    typedef enum logic [1:0] {
        DSOM_ST_IDLE = 2'b00,
        DSOM_ST_STOP = 2'b01,
        DSOM_ST_FAULT = 2'b10
    } dsom_fsm_t;

    // object access request from the fieldbus side
    typedef struct packed {
        logic wr;
        logic rd;
        logic pdo;
        logic [15:0] index;
        logic [15:0] wdata;
    } dsom_od_req_t;

    // object access answer
    typedef struct packed {
        logic ack;
        logic err;
        logic [15:0] rdata;
    } dsom_od_rsp_t;

    // drive state machine events, one-cycle pulses
    typedef struct packed {
        logic quick_stop;
        logic shutdown;
        logic disable_op;
        logic alarm;
        logic fault_reset;
    } dsom_evt_t;

    // feedback from the motion core
    typedef struct packed {
        logic speed_zero;
        logic target_hit;
        logic stopped;
    } dsom_fb_t;

    // nonvolatile store request
    typedef struct packed {
        logic wr;
        logic [15:0] index;
        logic [15:0] data;
    } dsom_nv_t;

    // complete block state
    typedef struct packed {
        dsom_fsm_t fsm;
        dsom_act_t act;
        logic to_sod;
        logic torque_zero;
        logic [15:0] opt_qstop;
        logic [15:0] opt_shut;
        logic [15:0] opt_disop;
        logic [15:0] opt_halt;
        logic [15:0] opt_fault;
        logic [7:0] mode_sel;
        logic [7:0] mode_act;
        logic [15:0] status;
        dsom_od_rsp_t rsp;
        dsom_nv_t nv;
    } dsom_st_t;

endpackage

/* tb/dsom_ctrl_assertions.sv */
// port-level checks of the stop-option and mode-select block
`timescale 1ns/1ns
`include "dsom_map.svh"
module dsom_ctrl_assertions #(
    parameter int RATE_W = 32
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire dsom_pkg::dsom_od_req_t od_req,
    input wire dsom_pkg::dsom_od_rsp_t od_rsp,
    input wire logic [15:0] ctrl_word,
    input wire dsom_pkg::dsom_evt_t evt,
    input wire dsom_pkg::dsom_fb_t fb,
    input wire logic [RATE_W-1:0] profile_decel,
    input wire logic [RATE_W-1:0] homing_accel,
    input wire logic [RATE_W-1:0] quick_decel,
    input wire dsom_pkg::dsom_act_t stop_act,
    input wire logic [RATE_W-1:0] decel_rate,
    input wire logic torque_zero,
    input wire logic to_sod,
    input wire logic [15:0] status_bits,
    input wire logic [7:0] mode_display,
    input wire dsom_pkg::dsom_nv_t nv_store
);
    import dsom_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic tq_m;
    logic idle_m;
    // idle seen from outside: no stop running and no exit pulse
    assign tq_m = (mode_display == `DSOM_MODE_PT) || (mode_display == `DSOM_MODE_CST);
    assign idle_m = (stop_act == DSOM_ACT_NONE) && !to_sod;

    // ****************************************************************
    // object access
    // ****************************************************************
    req_ack_a: assert property ((od_req.wr || od_req.rd) |=> od_rsp.ack)
        else $error("object request not answered next cycle");
    pdo_refuse_a: assert property (od_req.wr && od_req.pdo
        && od_req.index inside {[`DSOM_IDX_QSTOP:`DSOM_IDX_FAULT]}
        |=> od_rsp.err && !nv_store.wr)
        else $error("process data write to an option accepted");
    disp_ro_a: assert property (od_req.wr && od_req.index == `DSOM_IDX_MDISP
        |=> od_rsp.ack && od_rsp.err)
        else $error("write to mode display accepted");

    // ****************************************************************
    // status bits and stop behaviour
    // ****************************************************************
    unused_zero_a: assert property ((status_bits & 16'hCBFF) == 16'h0000)
        else $error("unused status bit set");
    pv_speed_a: assert property ($past(mode_display) == `DSOM_MODE_PV
        |-> status_bits[12] == $past(fb.speed_zero) && !status_bits[13])
        else $error("velocity mode bits 12/13 wrong");
    pt_resv_a: assert property ($past(mode_display) == `DSOM_MODE_PT
        |-> status_bits[13:12] == 2'b00)
        else $error("torque mode reserved bits set");
    reach_bit_a: assert property ($past(mode_display) inside {`DSOM_MODE_PV, `DSOM_MODE_PT}
        |-> status_bits[10] == ($past(ctrl_word[8]) ? $past(fb.stopped)
        : $past(fb.target_hit)))
        else $error("bit 10 does not follow halt selection");
    tq_srvoff_a: assert property (evt.quick_stop && idle_m && tq_m
        |=> stop_act == DSOM_ACT_SRVOFF)
        else $error("torque mode quick stop not servo off");
    tq_halt_a: assert property (ctrl_word[8] && idle_m && tq_m |=> torque_zero)
        else $error("torque reference not forced to zero on halt");
    quick_rate_a: assert property (stop_act == DSOM_ACT_DEC_QUICK
        |-> decel_rate == quick_decel)
        else $error("quick stop rate not taken");
    cov_quick_c: cover property (stop_act == DSOM_ACT_DEC_QUICK);
    cov_sod_c: cover property (to_sod);
    cov_tz_c: cover property (torque_zero);
endmodule

bind dsom_ctrl dsom_ctrl_assertions #(.RATE_W(RATE_W)) chk_u (
    .mclk(mclk), .reset_n(reset_n), .od_req(od_req), .od_rsp(od_rsp),
    .ctrl_word(ctrl_word), .evt(evt), .fb(fb), .profile_decel(profile_decel),
    .homing_accel(homing_accel), .quick_decel(quick_decel), .stop_act(stop_act),
    .decel_rate(decel_rate), .torque_zero(torque_zero), .to_sod(to_sod),
    .status_bits(status_bits), .mode_display(mode_display), .nv_store(nv_store)
);

/* tb/dsom_motion_model.sv */
// motion core stand-in: reports standstill some cycles after a ramp starts
`timescale 1ns/1ns
module dsom_motion_model (
    // clock and command
    input wire logic mclk,
    input wire dsom_pkg::dsom_act_t stop_act,
    // stimulus knobs
    input wire logic slow,
    input wire logic tgt,
    // feedback
    output dsom_pkg::dsom_fb_t fb
);
    import dsom_pkg::*;
    int cnt;
    initial begin
        fb = '0;
        cnt = 0;
    end
    // a servo-off stop is not a ramp, so it never reports standstill here
    always @(posedge mclk) begin
        if (stop_act inside {DSOM_ACT_DEC_NORM, DSOM_ACT_DEC_QUICK, DSOM_ACT_DEC_TLIM}) begin
            cnt <= cnt + 1;
        end else begin
            cnt <= 0;
        end
        fb.stopped <= (cnt >= (slow ? 8 : 1));
        fb.speed_zero <= (cnt >= (slow ? 8 : 1));
        fb.target_hit <= tgt;
    end
endmodule

/* tb/dsom_ctrl_tb.sv */
// self-checking bench for the stop-option and mode-select block
`timescale 1ns/1ns
`include "dsom_map.svh"
module dsom_ctrl_tb;
    import dsom_pkg::*;
    logic mclk, reset_n, slow, tgt, torque_zero, to_sod, err_q, nv_q;
    dsom_od_req_t od_req;
    dsom_od_rsp_t od_rsp;
    dsom_evt_t evt;
    dsom_fb_t fb;
    dsom_act_t stop_act;
    dsom_nv_t nv_store;
    logic [15:0] ctrl_word, status_bits, rd_q, v;
    logic [31:0] profile_decel, homing_accel, quick_decel, decel_rate, nvw_q;
    logic [7:0] mode_display;
    int n_fail, checked;
    logic [15:0] oi[5] = '{`DSOM_IDX_QSTOP, `DSOM_IDX_SHUT, `DSOM_IDX_DISOP,
        `DSOM_IDX_HALT, `DSOM_IDX_FAULT};
    logic [15:0] om[5] = '{`DSOM_MAX_QSTOP, `DSOM_MAX_SHUT, `DSOM_MAX_DISOP,
        `DSOM_MAX_HALT, `DSOM_MAX_FAULT};
    logic [7:0] mc[8] = '{1, 3, 4, 6, 7, 8, 9, 10};
    logic [7:0] sm[3] = '{`DSOM_MODE_PP, `DSOM_MODE_HM, `DSOM_MODE_PT};

    dsom_ctrl dut_u (.mclk(mclk), .reset_n(reset_n), .od_req(od_req), .od_rsp(od_rsp),
        .ctrl_word(ctrl_word), .evt(evt), .fb(fb), .profile_decel(profile_decel),
        .homing_accel(homing_accel), .quick_decel(quick_decel), .stop_act(stop_act),
        .decel_rate(decel_rate), .torque_zero(torque_zero), .to_sod(to_sod),
        .status_bits(status_bits), .mode_display(mode_display), .nv_store(nv_store));
    dsom_motion_model core_u (.mclk(mclk), .stop_act(stop_act), .slow(slow), .tgt(tgt),
        .fb(fb));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // one access; starts and ends on a rising edge, answer taken one cycle on
    task automatic od(input logic w, input logic p, input logic [15:0] idx,
        input logic [15:0] d);
        od_req <= '{wr: w, rd: !w, pdo: p, index: idx, wdata: d};
        @(posedge mclk);
        od_req <= '0;
        #1;
        err_q = od_rsp.err;
        rd_q = od_rsp.rdata;
        nv_q = nv_store.wr;
        nvw_q = {nv_store.index, nv_store.data};
        chk("ack", 1, od_rsp.ack);
        @(posedge mclk);
    endtask
    task automatic wr(input logic [15:0] idx, input logic [15:0] d, input logic ok);
        od(1'b1, 1'b0, idx, d);
        chk("refused", !ok, err_q);
        chk("nv write", ok, nv_q);
        if (ok) chk("nv word", {idx, d}, nvw_q);
    endtask
    task automatic rd(input logic [15:0] idx, input logic [15:0] exp);
        od(1'b0, 1'b0, idx, 16'h0000);
        chk("read data", exp, rd_q);
    endtask
    function automatic dsom_act_t exp_stop(input logic [15:0] o, input logic [7:0] m);
        if (m == `DSOM_MODE_PT || m == `DSOM_MODE_CST) return DSOM_ACT_SRVOFF;
        case (o)
            16'h0001: return DSOM_ACT_DEC_NORM;
            16'h0002: return DSOM_ACT_DEC_QUICK;
            16'h0003: return DSOM_ACT_DEC_TLIM;
            default: return DSOM_ACT_SRVOFF;
        endcase
    endfunction
    function automatic logic [31:0] exp_rate(input dsom_act_t a, input logic [7:0] m);
        if (a == DSOM_ACT_DEC_QUICK) return quick_decel;
        return (m == `DSOM_MODE_HM) ? homing_accel : profile_decel;
    endfunction
    // event pulse (bit of the event struct), then wait for the exit pulse
    task automatic stop_run(input int b, input dsom_act_t exp, input logic [7:0] m);
        int n;
        evt <= dsom_evt_t'(5'b00001 << b);
        @(posedge mclk);
        evt <= '0;
        #1;
        chk("stop action", exp, stop_act);
        if (exp inside {DSOM_ACT_DEC_NORM, DSOM_ACT_DEC_QUICK}) begin
            chk("decel rate", exp_rate(exp, m), decel_rate);
        end
        n = 0;
        while (to_sod !== 1'b1 && n < 40) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk("to switch-on-disabled", 1, to_sod);
        @(posedge mclk);
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ****************************************************************
    // clock, watchdog, main sequence
    // ****************************************************************
    initial begin
        mclk = 0;
        forever #20 mclk = ~mclk;
    end
    // generous bound on the whole sequence, far above its few hundred cycles
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        wrap_up();
    end
    initial begin
        reset_n = 0; od_req = '0; ctrl_word = '0; evt = '0; slow = 0; tgt = 0;
        n_fail = 0; checked = 0;
        void'($urandom(67864));
        profile_decel = $urandom; homing_accel = $urandom; quick_decel = $urandom;
        repeat (5) @(posedge mclk);
        reset_n <= 1;
        @(posedge mclk);
        rd(`DSOM_IDX_QSTOP, `DSOM_RST_QSTOP);
        rd(`DSOM_IDX_SHUT, `DSOM_RST_SHUT);
        rd(`DSOM_IDX_DISOP, `DSOM_RST_DISOP);
        rd(`DSOM_IDX_HALT, `DSOM_RST_HALT);
        rd(`DSOM_IDX_FAULT, `DSOM_RST_FAULT);
        rd(`DSOM_IDX_MODE, {8'h00, `DSOM_RST_MODE});
        // each option: random legal value kept, one past the top refused
        for (int i = 0; i < 5; i++) begin
            v = 16'($urandom_range(om[i]));
            wr(oi[i], v, 1'b1);
            wr(oi[i], om[i] + 16'h0001, 1'b0);
            od(1'b1, 1'b1, oi[i], 16'h0000);
            chk("pdo write refused", 1, err_q);
            rd(oi[i], v);
        end
        foreach (mc[i]) begin
            wr(`DSOM_IDX_MODE, {8'h00, mc[i]}, 1'b1);
            rd(`DSOM_IDX_MDISP, {8'h00, mc[i]});
        end
        wr(`DSOM_IDX_MODE, 16'h0002, 1'b1);
        wr(`DSOM_IDX_MODE, 16'h0005, 1'b1);
        wr(`DSOM_IDX_MODE, 16'h0000, 1'b1);
        wr(`DSOM_IDX_MODE, 16'h000B, 1'b0);
        rd(`DSOM_IDX_MDISP, 16'h000A);
        wr(`DSOM_IDX_MDISP, 16'h0001, 1'b0);
        // quick stop options across position, homing and torque modes
        foreach (sm[j]) begin
            for (int o = 0; o < 5; o++) begin
                slow <= 1'($urandom);
                wr(`DSOM_IDX_MODE, {8'h00, sm[j]}, 1'b1);
                wr(`DSOM_IDX_QSTOP, 16'(o), 1'b1);
                stop_run(4, exp_stop(16'(o), sm[j]), sm[j]);
            end
        end
        // shutdown and disable-operation options, position and cyclic torque
        for (int o = 0; o < 4; o++) begin
            v = (o < 2) ? {8'h00, `DSOM_MODE_PP} : {8'h00, `DSOM_MODE_CST};
            wr(`DSOM_IDX_MODE, v, 1'b1);
            wr(`DSOM_IDX_SHUT, 16'(o % 2), 1'b1);
            stop_run(3, exp_stop(16'(o % 2), v[7:0]), v[7:0]);
            wr(`DSOM_IDX_DISOP, 16'(o % 2), 1'b1);
            stop_run(2, exp_stop(16'(o % 2), v[7:0]), v[7:0]);
        end
        // halt options keep the drive enabled: no exit pulse
        wr(`DSOM_IDX_MODE, {8'h00, `DSOM_MODE_PP}, 1'b1);
        for (int o = 1; o < 4; o++) begin
            wr(`DSOM_IDX_HALT, 16'(o), 1'b1);
            ctrl_word <= 16'h0100;
            repeat (3) @(posedge mclk);
            #1;
            chk("halt action", exp_stop(16'(o), 8'h01), stop_act);
            chk("halt no exit", 0, to_sod);
            ctrl_word <= 16'h0000;
            repeat (3) @(posedge mclk);
        end
        // status bits: velocity, torque under halt, velocity halted to standstill
        foreach (sm[j]) begin
            v = (j == 1) ? 16'h0004 : 16'h0003;
            tgt <= 1'($urandom);
            wr(`DSOM_IDX_MODE, v, 1'b1);
            ctrl_word <= (j != 0) ? 16'h0100 : 16'h0000;
            // long enough for a slow ramp to report standstill
            repeat (13) @(posedge mclk);
            #1;
            chk("status bits", (j == 1) ? 16'h0000 : (j == 2) ? 16'h1400 :
                {5'h00, tgt, 10'h000}, status_bits);
            if (v == 16'h0004) chk("torque zero", 1, torque_zero);
            ctrl_word <= 16'h0000;
            @(posedge mclk);
        end
        // alarm forces servo off until fault reset; quick stop meanwhile ignored
        evt <= '{alarm: 1'b1, default: 1'b0};
        @(posedge mclk);
        evt <= '{quick_stop: 1'b1, default: 1'b0};
        @(posedge mclk);
        evt <= '0;
        repeat (3) @(posedge mclk);
        #1;
        chk("fault action", DSOM_ACT_SRVOFF, stop_act);
        @(posedge mclk);
        evt <= '{fault_reset: 1'b1, default: 1'b0};
        @(posedge mclk);
        evt <= '0;
        repeat (2) @(posedge mclk);
        #1;
        chk("after fault reset", DSOM_ACT_NONE, stop_act);
        wrap_up();
    end
endmodule
